// ==== shared/uart_lsr_regs.vh ====
`ifndef UART_LSR_REGS_VH
`define UART_LSR_REGS_VH
// ---------------------------------------------------------------------------
// Register offsets (byte addresses, 8-bit address bus)
// ---------------------------------------------------------------------------
`define ADDR_LINE_STATUS   8'h05
`define ADDR_IRQ_STATUS    8'h10
`define ADDR_IRQ_MASK      8'h14
`define ADDR_CONTROL       8'h18
// ---------------------------------------------------------------------------
// Line status field positions
// ---------------------------------------------------------------------------
`define BIT_RX_FIFO_ERR    7
`define BIT_TX_ALL_EMPTY   6
`define BIT_TX_HOLD_EMPTY  5
`define BIT_BREAK          4
`define BIT_FRAMING_ERR    3
// Interrupt status bit positions
`define IRQ_BIT_HOLD_EMPTY 0
`define IRQ_BIT_BREAK      1
`define IRQ_BIT_FRAME      2
`define IRQ_BIT_RXERR      3
// Control register bits
`define CTRL_BIT_FIFO_MODE 0
`define CTRL_BIT_THR_IE    1
// Reset values
`define RST_CONTROL        8'h00
`define RST_IRQ_MASK       8'h00
// Receive FIFO depth, entries
`define RX_FIFO_DEPTH      32
`define RX_PTR_W           5
`endif

// ==== design/rx_tag_mem.v ====
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Error tag memory for receive FIFO entries, registered read
// ---------------------------------------------------------------------------
`include "uart_lsr_regs.vh"
module rx_tag_mem (
  // Clock
  input  wire                   core_clk,
  // Write side
  input  wire                   wr_en,
  input  wire [`RX_PTR_W-1:0]   wr_addr,
  input  wire [2:0]             wr_data,
  // Read side
  input  wire [`RX_PTR_W-1:0]   rd_addr,
  output reg  [2:0]             rd_data_ff
);
  reg [2:0] mem [0:`RX_FIFO_DEPTH-1];

  // Write port, no reset on storage
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always @(posedge core_clk) begin
    rd_data_ff <= mem[rd_addr];
  end
endmodule // rx_tag_mem

// ==== design/uart_line_status_flags.v ====
`timescale 1ns/1ns
// Function
// (RULE1) Bit 7 set while any FIFO entry carries parity, framing or break; the code read-clears it even while such entries remain.
// (RULE2) Reading line status clears bit 7.
// (RULE3) Non-FIFO: bit 6 high when holding and shift registers both empty.
// (RULE4) Bit 6 low whenever holding or shift register holds a character; in FIFO mode the code ignores the holding register (thr_full).
// (RULE5) FIFO mode: bit 6 high only when transmit FIFO and shift empty.
// (RULE6) Non-FIFO: bit 5 set when holding register moves into shift register.
// (RULE7) Bit 5 cleared in the cycle the host writes the holding register.
// (RULE8) Interrupt while bit 5 set and holding interrupt enable set.
// (RULE9) FIFO mode: bit 5 set when transmit FIFO empties, cleared on write.
// (RULE10) Bit 4 set when receive input low a full frame; resets to 0.
// (RULE11) FIFO mode: only one break character loaded per break condition.
// (RULE12) Bit 3 zero after reset and when no framing error applies.
// (RULE13) Bit 3 set on missing stop bit; FIFO mode reports top entry.
// (RULE14) Host writes to line status are ignored.
`include "uart_lsr_regs.vh"
module uart_line_status_flags (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Register port
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata_ff,
  // Transmit side state
  input  wire        thr_write,
  input  wire        thr_to_tsr,
  input  wire        thr_full,
  input  wire        tsr_busy,
  input  wire        tx_fifo_empty,
  // Receiver events
  input  wire        rx_char_done,
  input  wire        rx_parity_err,
  input  wire        rx_frame_err,
  input  wire        rx_break_frame,
  input  wire        rx_line_high,
  input  wire        rx_pop,
  // Receive FIFO load request
  output wire        rx_push,
  output reg  [2:0]  rx_top_tags_ff,
  // Interrupt
  output wire        irq,
  output wire        thr_irq
);
  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function sel;
    input [7:0] a;
    input [7:0] ref_a;
    begin
      sel = (a == ref_a);
    end
  endfunction

  reg  [7:0]             ctrl_ff;
  reg  [3:0]             irq_mask_ff;
  reg  [3:0]             irq_stat_ff;
  reg                    hold_empty_ff;
  reg                    break_ff;
  reg                    frame_ff;
  reg                    rx_err_ff;
  reg                    in_break_ff;
  reg  [`RX_PTR_W-1:0]   wptr_ff;
  reg  [`RX_PTR_W-1:0]   rptr_ff;
  reg  [`RX_PTR_W:0]     count_ff;
  reg  [`RX_PTR_W:0]     err_count_ff;
  wire [2:0]             rd_tags;
  wire                   fifo_mode;
  wire                   rd_lsr;
  wire                   all_empty;
  wire                   pop_ok;
  wire                   push_err;
  wire                   pop_err;
  wire [7:0]             lsr_val;
  wire [3:0]             irq_events;

  assign fifo_mode = ctrl_ff[`CTRL_BIT_FIFO_MODE];
  assign rd_lsr    = rd && sel(addr, `ADDR_LINE_STATUS);

  // -------------------------------------------------------------------------
  // Software registers
  // -------------------------------------------------------------------------
  // Control and mask writes; line status has no write path
  // (RULE14) writes ignored
  always @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_ff     <= `RST_CONTROL;
      irq_mask_ff <= 4'h0;
    end else if (wr) begin
      if (sel(addr, `ADDR_CONTROL)) begin
        ctrl_ff <= wdata;
      end
      if (sel(addr, `ADDR_IRQ_MASK)) begin
        irq_mask_ff <= wdata[3:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Transmit flags
  // -------------------------------------------------------------------------
  // (RULE3) (RULE4) (RULE5) empty combine
  assign all_empty = fifo_mode ? (tx_fifo_empty && !tsr_busy)
                               : (!thr_full && !tsr_busy);

  // Holding-empty flag; a host write wins over a simultaneous transfer
  always @(posedge core_clk) begin
    if (!rstn) begin
      hold_empty_ff <= 1'b1;
    // (RULE7) clear on write
    end else if (thr_write) begin
      hold_empty_ff <= 1'b0;
    // (RULE9) FIFO emptied
    end else if (fifo_mode) begin
      hold_empty_ff <= tx_fifo_empty ? 1'b1 : hold_empty_ff;
    // (RULE6) moved to shifter
    end else if (thr_to_tsr) begin
      hold_empty_ff <= 1'b1;
    end
  end

  // (RULE8) holding interrupt
  assign thr_irq = hold_empty_ff && ctrl_ff[`CTRL_BIT_THR_IE];

  // -------------------------------------------------------------------------
  // Break handling
  // -------------------------------------------------------------------------
  // One break entry per condition; rearmed once the line idles high
  // (RULE11) single break load
  always @(posedge core_clk) begin
    if (!rstn) begin
      in_break_ff <= 1'b0;
    end else if (rx_char_done && rx_break_frame) begin
      in_break_ff <= 1'b1;
    end else if (rx_line_high) begin
      in_break_ff <= 1'b0;
    end
  end

  assign rx_push = rx_char_done && !(rx_break_frame && in_break_ff)
                   && (count_ff != `RX_FIFO_DEPTH);

  // -------------------------------------------------------------------------
  // Receive tag FIFO
  // -------------------------------------------------------------------------
  rx_tag_mem u_tags (
    .core_clk   (core_clk),
    .wr_en      (rx_push && fifo_mode),
    .wr_addr    (wptr_ff),
    .wr_data    ({rx_break_frame, rx_frame_err, rx_parity_err}),
    .rd_addr    (rx_pop ? rptr_ff + 1'b1 : rptr_ff),
    .rd_data_ff (rd_tags)
  );

  assign pop_ok   = rx_pop && (count_ff != 0);
  assign push_err = rx_push && fifo_mode && (rx_break_frame || rx_frame_err || rx_parity_err);
  assign pop_err  = pop_ok && (rx_top_tags_ff != 3'h0);

  // Pointers, fill count and count of erroneous entries held
  always @(posedge core_clk) begin
    if (!rstn || !fifo_mode) begin
      wptr_ff      <= {`RX_PTR_W{1'b0}};
      rptr_ff      <= {`RX_PTR_W{1'b0}};
      count_ff     <= 6'h00;
      err_count_ff <= 6'h00;
    end else begin
      if (rx_push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop_ok) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      count_ff     <= count_ff + {5'h00, rx_push} - {5'h00, pop_ok};
      err_count_ff <= err_count_ff + {5'h00, push_err} - {5'h00, pop_err};
    end
  end

  // Top entry tags; memory read lags one cycle so track count too.
  // A freshly pushed entry into an empty FIFO shows up here two
  // cycles after the push; software reading sooner sees the old top.
  // Trade-off: no bypass path, keeping the read port fully registered.
  always @(posedge core_clk) begin
    if (!rstn) begin
      rx_top_tags_ff <= 3'h0;
    end else if (count_ff == 0 && !rx_push) begin
      rx_top_tags_ff <= 3'h0;
    end else begin
      rx_top_tags_ff <= rd_tags;
    end
  end

  // -------------------------------------------------------------------------
  // Receive flags
  // -------------------------------------------------------------------------
  // Set beats the read-clear so a coinciding event is kept.
  // In FIFO mode the framing bit is not read-cleared: it tracks the
  // top entry and changes when that entry is popped or a push fills an empty FIFO.
  always @(posedge core_clk) begin
    if (!rstn) begin
      break_ff  <= 1'b0;
      frame_ff  <= 1'b0;
      rx_err_ff <= 1'b0;
    end else begin
      // (RULE10) break detect
      if (rx_char_done && rx_break_frame) begin
        break_ff <= 1'b1;
      end else if (rd_lsr) begin
        break_ff <= 1'b0;
      end
      // (RULE12) (RULE13) framing report
      if (fifo_mode) begin
        frame_ff <= rx_top_tags_ff[1];
      end else if (rx_char_done) begin
        frame_ff <= rx_frame_err;
      end else if (rd_lsr) begin
        frame_ff <= 1'b0;
      end
      // (RULE1) (RULE2) error aggregate
      if (push_err) begin
        rx_err_ff <= 1'b1;
      end else if (rd_lsr || err_count_ff == 0) begin
        rx_err_ff <= 1'b0;
      end
    end
  end

  assign lsr_val = {rx_err_ff, all_empty, hold_empty_ff, break_ff, frame_ff, 3'b000};

  // -------------------------------------------------------------------------
  // Interrupt status, cleared by read, set wins
  // -------------------------------------------------------------------------
  assign irq_events = {push_err, rx_char_done && rx_frame_err,
                       rx_char_done && rx_break_frame, thr_to_tsr || (fifo_mode && tx_fifo_empty)};

  always @(posedge core_clk) begin
    if (!rstn) begin
      irq_stat_ff <= 4'h0;
    end else if (rd && sel(addr, `ADDR_IRQ_STATUS)) begin
      irq_stat_ff <= irq_events;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_events;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff) || thr_irq;

  // -------------------------------------------------------------------------
  // Read data, one cycle after strobe
  // -------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_LINE_STATUS: rdata_ff <= lsr_val;
        `ADDR_IRQ_STATUS:  rdata_ff <= {4'h0, irq_stat_ff};
        `ADDR_IRQ_MASK:    rdata_ff <= {4'h0, irq_mask_ff};
        `ADDR_CONTROL:     rdata_ff <= ctrl_ff;
        default:           rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
endmodule // uart_line_status_flags

// ==== verification/uart_line_status_flags_asserts.sv ====
`timescale 1ns/1ns
`include "uart_lsr_regs.vh"
module uart_lsr_checker (
  // Clock, reset and register port
  input wire       core_clk,
  input wire       rstn,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata_ff,
  // Transmit and receive side
  input wire       thr_write,
  input wire       thr_to_tsr,
  input wire       thr_full,
  input wire       tsr_busy,
  input wire       tx_fifo_empty,
  input wire       rx_break_frame,
  input wire       rx_line_high,
  input wire       rx_push,
  input wire [2:0] rx_top_tags_ff,
  // Interrupt
  input wire       thr_irq
);
  reg  mode_ff;
  reg  ie_ff;
  reg  armed_ff;
  wire lsr_rd = rd && addr == `ADDR_LINE_STATUS;
  wire quiet  = !wr && !thr_write;
  wire temt   = mode_ff ? tx_fifo_empty && !tsr_busy : !thr_full && !tsr_busy;
  // Shadow control bits from bus writes, so no internal probes are needed
  always @(posedge core_clk) begin
    if (!rstn) begin
      mode_ff  <= 1'b0;
      ie_ff    <= 1'b0;
      armed_ff <= 1'b1;
    end else begin
      if (wr && addr == `ADDR_CONTROL) begin
        mode_ff <= wdata[`CTRL_BIT_FIFO_MODE];
        ie_ff   <= wdata[`CTRL_BIT_THR_IE];
      end
      if (rx_line_high)
        armed_ff <= 1'b1;
      else if (rx_push && rx_break_frame)
        armed_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle:
    assert property (!rd |=> rdata_ff == 8'h00) else $error("read data not zero outside answer");
  a_tx_all_empty:
    assert property (lsr_rd |=> rdata_ff[6] == $past(temt)) else $error("transmit empty bit wrong");
  a_hold_clear_write:
    assert property (thr_write |=> !thr_irq) else $error("holding empty not cleared by write");
  a_hold_set_move:
    assert property (!mode_ff && ie_ff && thr_to_tsr && quiet |=> thr_irq) else $error("holding empty not set");
  a_fifo_hold_follow:
    assert property (mode_ff && ie_ff && tx_fifo_empty && quiet |=> thr_irq) else $error("fifo empty not flagged");
  a_irq_needs_enable:
    assert property (thr_irq |-> ie_ff) else $error("holding interrupt while disabled");
  a_break_once:
    assert property (rx_push && rx_break_frame && mode_ff |-> armed_ff) else $error("repeat break loaded");
  a_frame_top:
    assert property (lsr_rd && mode_ff |=> rdata_ff[3] == $past(rx_top_tags_ff[1])) else $error("framing bit wrong");
  c_break_push: cover property (rx_push && rx_break_frame && mode_ff);
  c_hold_irq: cover property (thr_irq);
  c_fifo_read: cover property (lsr_rd && mode_ff);
endmodule // uart_lsr_checker
bind uart_line_status_flags uart_lsr_checker chk_u (
  .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
  .thr_write(thr_write), .thr_to_tsr(thr_to_tsr), .thr_full(thr_full), .tsr_busy(tsr_busy),
  .tx_fifo_empty(tx_fifo_empty), .rx_break_frame(rx_break_frame), .rx_line_high(rx_line_high),
  .rx_push(rx_push), .rx_top_tags_ff(rx_top_tags_ff), .thr_irq(thr_irq));

// ==== verification/host_bus_model.sv ====
`timescale 1ns/1ns
module host_bus_model (
  // Clock
  input  wire        core_clk,
  // Register bus
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic       wr,
  output logic       rd,
  input  wire  [7:0] rdata_ff
);
  // Idle bus from time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write strobe
  task put(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task get(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata_ff;
  endtask
endmodule // host_bus_model

// ==== verification/uart_line_status_flags_tb_top.sv ====
`timescale 1ns/1ns
`include "uart_lsr_regs.vh"
module uart_line_status_flags_tb_top;
  logic core_clk = 1'b0, rstn = 1'b0, thr_write = 1'b0, thr_to_tsr = 1'b0, thr_full = 1'b0, tsr_busy = 1'b0;
  logic tx_fifo_empty = 1'b1, rx_char_done = 1'b0, rx_parity_err = 1'b0, rx_frame_err = 1'b0;
  logic rx_break_frame = 1'b0, rx_line_high = 1'b1, rx_pop = 1'b0, pv;
  logic [7:0] rv;
  wire  [7:0] addr, wdata, rdata_ff;
  wire  [2:0] rx_top_tags_ff;
  wire        wr, rd, rx_push, irq, thr_irq;
  int err_count = 0;
  int samples_checked = 0;
  always #2 core_clk = ~core_clk;
  host_bus_model host_u (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff));
  uart_line_status_flags dut_u (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .thr_write(thr_write), .thr_to_tsr(thr_to_tsr), .thr_full(thr_full), .tsr_busy(tsr_busy),
    .tx_fifo_empty(tx_fifo_empty), .rx_char_done(rx_char_done), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err), .rx_break_frame(rx_break_frame), .rx_line_high(rx_line_high), .rx_pop(rx_pop),
    .rx_push(rx_push), .rx_top_tags_ff(rx_top_tags_ff), .irq(irq), .thr_irq(thr_irq));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Masked register compare
  task rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    host_u.get(a, rv);
    check(rv & m, exp);
  endtask
  task tx_ev(input logic w, input logic m, input logic full, input logic busy, input logic fe);
    @(posedge core_clk);
    {thr_write, thr_to_tsr, thr_full, tsr_busy, tx_fifo_empty} <= {w, m, full, busy, fe};
    @(posedge core_clk);
    {thr_write, thr_to_tsr} <= 2'b00;
  endtask
  // Break chars hold the line low afterwards; others release it
  task rx_char(input logic [2:0] bfp, output logic push);
    @(posedge core_clk);
    rx_char_done <= 1'b1;
    {rx_break_frame, rx_frame_err, rx_parity_err} <= bfp;
    rx_line_high <= !bfp[2];
    #1 push = rx_push;
    @(posedge core_clk);
    rx_char_done <= 1'b0;
  endtask
  // Extra cycles let the registered tag read settle
  task pop;
    @(posedge core_clk);
    rx_pop <= 1'b1;
    @(posedge core_clk);
    rx_pop <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task t_reset;
    rdchk(`ADDR_LINE_STATUS, 8'hFF, 8'h60);
    rdchk(`ADDR_CONTROL, 8'hFF, `RST_CONTROL);
    rdchk(`ADDR_IRQ_MASK, 8'hFF, `RST_IRQ_MASK);
    rdchk(8'h20, 8'hFF, 8'h00);
  endtask
  task t_tx_plain;
    host_u.put(`ADDR_CONTROL, 8'h02);
    #1 check({7'h00, thr_irq}, 8'h01);
    tx_ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    #1 check({7'h00, thr_irq}, 8'h00);
    rdchk(`ADDR_LINE_STATUS, 8'hFF, 8'h00);
    tx_ev(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    rdchk(`ADDR_LINE_STATUS, 8'hFF, 8'h20);
    tx_ev(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    host_u.put(`ADDR_LINE_STATUS, 8'h00);
    rdchk(`ADDR_LINE_STATUS, 8'hFF, 8'h60);
    host_u.put(`ADDR_CONTROL, 8'h00);
  endtask
  task t_break;
    rx_char(3'b100, pv);
    rdchk(`ADDR_LINE_STATUS, 8'h10, 8'h10);
    rdchk(`ADDR_LINE_STATUS, 8'h10, 8'h00);
    check({7'h00, irq}, 8'h00);
    host_u.put(`ADDR_IRQ_MASK, 8'h02);
    #1 check({7'h00, irq}, 8'h01);
    rdchk(`ADDR_IRQ_STATUS, 8'h02, 8'h02);
    check({7'h00, irq}, 8'h00);
    host_u.put(`ADDR_IRQ_MASK, 8'h00);
  endtask
  task t_fifo;
    host_u.put(`ADDR_CONTROL, 8'h03);
    tx_ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    rdchk(`ADDR_LINE_STATUS, 8'h60, 8'h60);
    tx_ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    rdchk(`ADDR_LINE_STATUS, 8'h60, 8'h00);
    tx_ev(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rdchk(`ADDR_LINE_STATUS, 8'h60, 8'h60);
    // Parity, framing and break tags in turn
    for (int k = 0; k < 3; k++) begin
      rx_char(3'b001 << k, pv);
      repeat (2) @(posedge core_clk);
      #1 check({5'h00, rx_top_tags_ff}, {5'h00, 3'b001 << k});
      rdchk(`ADDR_LINE_STATUS, 8'h88, {1'b1, 3'h0, k == 1, 3'h0});
      rdchk(`ADDR_LINE_STATUS, 8'h88, {4'h0, k == 1, 3'h0});
      pop;
    end
    rdchk(`ADDR_LINE_STATUS, 8'h08, 8'h00);
    rx_char(3'b000, pv);
    rx_char(3'b100, pv);
    check({7'h00, pv}, 8'h01);
    rx_char(3'b100, pv);
    check({7'h00, pv}, 8'h00);
    rx_char(3'b000, pv);
    rx_char(3'b100, pv);
    check({7'h00, pv}, 8'h01);
  endtask
  task tally_and_finish;
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset;
    t_tx_plain;
    t_break;
    t_fifo;
    tally_and_finish;
  end
  // Watchdog at 5000 cycles, well beyond the roughly 120 cycles the run needs
  initial begin
    #20000;
    err_count++;
    tally_and_finish;
  end
endmodule // uart_line_status_flags_tb_top
